// ---- core/sfsl_slave.sv ----
// link slave end: shifts words both ways on the link clock and raises requests
`timescale 1ns/10ps
module sfsl_slave #(
  parameter int WIDTH = sfsl_pkg::WORD_WIDTH
) (
  sfsl_link_if.slave           link,
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [WIDTH-1:0] txWord,
  input  wire logic            txLoad,
  output logic                 txBusy,
  output logic [WIDTH-1:0]     rxWord,
  output logic                 rxValid,
  input  wire logic [15:0]     idleTimeoutBeforeSleep,
  input  wire logic            sleepWanted,
  output logic                 sleepAllowed
);
  // link-clock domain: sclk is the clock port; select high (deselect) async-clears shift and bit-count registers, rst clears rxHold_reg and rxToggle_reg
  logic                 selected;
  logic [WIDTH-1:0]     shiftIn_reg;
  logic [WIDTH-1:0]     shiftOut_reg;
  logic [$clog2(WIDTH)-1:0] bitCnt_reg;
  logic [WIDTH-1:0]     rxHold_reg;
  logic                 rxToggle_reg;
  logic [WIDTH-1:0]     txHold_reg;
  logic                 pending_reg;
  logic                 irq_reg;
  logic [2:0]           selSync_reg;
  logic [2:0]           rxSync_reg;
  logic                 selRise;
  logic                 outLive_reg;
  logic [15:0]          idleCnt_reg;

  assign selected = (link.targetSelectLow_n == sfsl_pkg::SELECT_ACTIVE);

  // sample on rising edge, only while selected; reset by deselect
  always_ff @(posedge link.sclk or posedge link.targetSelectLow_n) begin
    if (link.targetSelectLow_n) begin
      bitCnt_reg  <= '0;
      shiftIn_reg <= sfsl_pkg::WORD_RESET;
    end else begin
      shiftIn_reg <= {shiftIn_reg[WIDTH-2:0], link.mosi};
      bitCnt_reg  <= (bitCnt_reg == $clog2(WIDTH)'(WIDTH - 1)) ? '0 : bitCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      rxHold_reg   <= sfsl_pkg::WORD_RESET;
      rxToggle_reg <= 1'b0;
    end else if (selected && bitCnt_reg == $clog2(WIDTH)'(WIDTH - 1)) begin
      rxHold_reg   <= {shiftIn_reg[WIDTH-2:0], link.mosi};
      rxToggle_reg <= ~rxToggle_reg;
    end
  end

  // drive next bit on falling edge; msb comes straight from hold word until then
  // reset stays constant: a word loaded after deselect must still reach the msb
  always_ff @(negedge link.sclk or posedge link.targetSelectLow_n) begin
    if (link.targetSelectLow_n) begin
      shiftOut_reg <= sfsl_pkg::WORD_RESET;
      outLive_reg  <= 1'b0;
    end else begin
      outLive_reg <= 1'b1;
      if (bitCnt_reg == '0) begin
        shiftOut_reg <= txHold_reg;
      end else if (!outLive_reg) begin
        shiftOut_reg <= {txHold_reg[WIDTH-2:0], 1'b0};
      end else begin
        shiftOut_reg <= {shiftOut_reg[WIDTH-2:0], 1'b0};
      end
    end
  end

  assign link.misoOut = outLive_reg ? shiftOut_reg[WIDTH-1] : txHold_reg[WIDTH-1];
  assign link.misoOe  = selected;

  // system-clock domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selSync_reg <= 3'h0;
      rxSync_reg  <= 3'h0;
    end else begin
      selSync_reg <= {selSync_reg[1:0], selected};
      rxSync_reg  <= {rxSync_reg[1:0], rxToggle_reg};
    end
  end
  assign selRise = selSync_reg[1] & ~selSync_reg[2];

  // tx word held steady while selected; host must load between accesses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txHold_reg  <= sfsl_pkg::WORD_RESET;
      pending_reg <= 1'b0;
    end else if (txLoad && !selSync_reg[1]) begin
      txHold_reg  <= txWord;
      pending_reg <= 1'b1;
    end else if (selRise) begin
      pending_reg <= 1'b0;
    end
  end
  assign txBusy = pending_reg | selSync_reg[1];

  // request: rising edge when data waits, dropped once selected
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (selSync_reg[1]) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= pending_reg;
    end
  end
  assign link.irq = irq_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxWord  <= sfsl_pkg::WORD_RESET;
      rxValid <= 1'b0;
    end else begin
      rxValid <= rxSync_reg[1] ^ rxSync_reg[2];
      if (rxSync_reg[1] ^ rxSync_reg[2]) begin
        rxWord <= rxHold_reg; // stable: toggle seen after two stages
      end
    end
  end

  // quiet span since last access or request; saturates so it never wraps to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idleCnt_reg <= '0;
    end else if (pending_reg || selSync_reg[1]) begin
      idleCnt_reg <= '0;
    end else if (idleCnt_reg != sfsl_pkg::TIMEOUT_NEVER) begin
      idleCnt_reg <= idleCnt_reg + 16'h0001;
    end
  end

  // power saving only after the quiet span, never when master declined it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleepAllowed <= 1'b0;
    end else begin
      sleepAllowed <= sleepWanted && !pending_reg && !selSync_reg[1]
                      && (idleCnt_reg > idleTimeoutBeforeSleep)
                      && (idleTimeoutBeforeSleep != sfsl_pkg::TIMEOUT_NEVER);
    end
  end
endmodule

// ---- core/sfsl_pkg.sv ----
// shared constants of the five-signal serial request link
// Contract
// - data flows both ways each access
// - slave starts exchange unasked when data ready (here the slave only raises irq; the master starts every access)
// - master uses one select per slave
// - select asserted low, inactive high
// - shared lines tolerate foreign traffic
// - slave drives interrupt to request access
// - interrupt rising edge, master detects edge
// - all-ones timeout forbids slave power saving
// - mode zero: clock idles low, rising sample
// - deselected slave keeps data output off
// - deselected slave ignores clock and data
package sfsl_pkg;
  localparam int          WORD_WIDTH      = 8;
  localparam int          TIMEOUT_WIDTH   = 16;
  localparam logic [15:0] TIMEOUT_NEVER   = 16'hFFFF;
  localparam logic [15:0] TIMEOUT_RESET   = 16'hFFFF;
  localparam int          CLK_DIV_HALF    = 2;
  localparam int          SELECT_GAP      = 4;
  localparam logic        SELECT_ACTIVE   = 1'b0;
  localparam logic [7:0]  WORD_RESET      = 8'h00;
endpackage

// ---- core/sfsl_link_if.sv ----
// interface joining the link master and the link slave
`timescale 1ns/10ps
interface sfsl_link_if;
  logic sclk;
  logic mosi;
  logic misoOut;
  logic misoOe;
  logic targetSelectLow_n;
  logic irq;
  logic miso;
  assign miso = misoOe ? misoOut : 1'b0;
  modport master (
    output sclk,
    output mosi,
    output targetSelectLow_n,
    input  miso,
    input  irq
  );
  modport slave (
    input  sclk,
    input  mosi,
    input  targetSelectLow_n,
    output misoOut,
    output misoOe,
    output irq
  );
endinterface

// ---- core/sfsl_master.sv ----
// link master end: divides its clock into sclk, selects one slave, catches requests
`timescale 1ns/10ps
module sfsl_master #(
  parameter int WIDTH = sfsl_pkg::WORD_WIDTH
) (
  sfsl_link_if.master          link,
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [WIDTH-1:0] txWord,
  input  wire logic            start,
  output logic                 busy,
  output logic [WIDTH-1:0]     rxWord,
  output logic                 rxValid,
  output logic                 requestSeen,
  output logic [15:0]          idleTimeoutBeforeSleep
);
  typedef enum {IDLE, SETUP, LOW, HIGH, GAP} sfsl_state_type;
  sfsl_state_type state_reg;
  logic [7:0]           div_reg;
  logic [$clog2(WIDTH):0] bits_reg;
  logic [WIDTH-1:0]     shift_reg;
  logic [2:0]           irqSync_reg;
  logic [1:0]           misoSync_reg;

  assign idleTimeoutBeforeSleep = sfsl_pkg::TIMEOUT_RESET;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqSync_reg  <= 3'h0;
      misoSync_reg <= 2'h0;
    end else begin
      irqSync_reg  <= {irqSync_reg[1:0], link.irq};
      misoSync_reg <= {misoSync_reg[0], link.miso};
    end
  end

  // edge, not level, so a stuck-high line is one request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      requestSeen <= 1'b0;
    end else begin
      requestSeen <= irqSync_reg[1] & ~irqSync_reg[2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= IDLE;
      div_reg   <= 8'h00;
      bits_reg  <= '0;
      shift_reg <= sfsl_pkg::WORD_RESET;
      rxWord    <= sfsl_pkg::WORD_RESET;
      rxValid   <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      case (state_reg)
        IDLE: begin
          if (start) begin
            shift_reg <= txWord;
            bits_reg  <= '0;
            div_reg   <= 8'h00;
            state_reg <= SETUP;
          end
        end
        SETUP: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == 8'(sfsl_pkg::CLK_DIV_HALF * 2 - 1)) begin
            div_reg   <= 8'h00;
            state_reg <= HIGH;
          end
        end
        HIGH: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == 8'(sfsl_pkg::CLK_DIV_HALF - 1)) begin
            // sampled miso lags two cycles, as long as one clock half, but miso changed a whole low half earlier
            shift_reg <= {shift_reg[WIDTH-2:0], misoSync_reg[1]};
            bits_reg  <= bits_reg + 1'b1;
            div_reg   <= 8'h00;
            state_reg <= LOW;
          end
        end
        LOW: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == 8'(sfsl_pkg::CLK_DIV_HALF - 1)) begin
            div_reg <= 8'h00;
            if (bits_reg == ($clog2(WIDTH)+1)'(WIDTH)) begin
              rxWord    <= shift_reg;
              rxValid   <= 1'b1;
              state_reg <= GAP;
            end else begin
              state_reg <= HIGH;
            end
          end
        end
        GAP: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == 8'(sfsl_pkg::SELECT_GAP - 1)) begin
            state_reg <= IDLE;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  // mode zero: clock low outside HIGH; mosi is the shift msb
  assign link.sclk = (state_reg == HIGH);
  assign link.mosi = shift_reg[WIDTH-1];
  assign link.targetSelectLow_n = !(state_reg == SETUP || state_reg == HIGH
                                    || state_reg == LOW);
  assign busy = (state_reg != IDLE);
endmodule

// ---- verification/sfsl_link_chk.sv ----
// assertions on the link wires between master and slave
`timescale 1ns/10ps
module sfsl_link_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe,
  input wire logic targetSelectLow_n,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  idle_clk_low_a: assert property (targetSelectLow_n |-> !sclk)
    else $error("sclk high while deselected");
  setup_clk_low_a: assert property ($fell(targetSelectLow_n) |-> !sclk [*4])
    else $error("sclk moved during select setup");
  clk_high_half_a: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("sclk high half not two cycles");
  mosi_steady_a: assert property ($rose(sclk) |=> $stable(mosi))
    else $error("mosi moved after rising sclk");
  miso_steady_a: assert property ($rose(sclk) |=> $stable(miso))
    else $error("miso moved after rising sclk");
  miso_off_a: assert property (targetSelectLow_n [*4] |-> !misoOe)
    else $error("miso driven while deselected");
  select_gap_a: assert property ($rose(targetSelectLow_n) |=> targetSelectLow_n [*3])
    else $error("select gap too short");
  irq_drop_a: assert property ($fell(targetSelectLow_n) |-> ##[0:20] !irq)
    else $error("irq stays high after select");
  irq_rise_idle_a: assert property ($rose(irq) |-> targetSelectLow_n)
    else $error("irq rose while selected");
  // main scenarios seen
  xfer_c: cover property ($fell(targetSelectLow_n));
  request_c: cover property ($rose(irq));
  miso_c: cover property (misoOe && miso);
endmodule

// ---- verification/sfsl_tb.sv ----
// testbench: both link ends joined, word exchange and request checks
`timescale 1ns/10ps
module sfsl_tb;
  logic        clk = 1'b0;
  logic        slaveClk = 1'b0;
  logic        rst = 1'b0;
  logic [7:0]  mTx = 8'h00;
  logic        start = 1'b0;
  logic        busy;
  logic [7:0]  mRx;
  logic        mRxValid;
  logic        requestSeen;
  logic [15:0] idleTimeout;
  logic [7:0]  sTx = 8'h00;
  logic        txLoad = 1'b0;
  logic        txBusy;
  logic [7:0]  sRx;
  logic        sRxValid;
  logic        sleepWanted = 1'b0;
  logic        sleepAllowed;
  logic [7:0]  sGot = 8'h00;
  logic [7:0]  mGot = 8'h00;
  int          reqCount = 0;
  logic [7:0]  sw [2] = '{8'hA5, 8'h81};
  logic [7:0]  mw [2] = '{8'h3C, 8'h7E};
  int          bad_count = 0;
  int          n_checks = 0;
  sfsl_link_if sfsl_link_if_i ();
  sfsl_master sfsl_master_i (.link(sfsl_link_if_i), .clk(clk), .rst(rst), .txWord(mTx),
    .start(start), .busy(busy), .rxWord(mRx), .rxValid(mRxValid),
    .requestSeen(requestSeen), .idleTimeoutBeforeSleep(idleTimeout));
  sfsl_slave sfsl_slave_i (.link(sfsl_link_if_i), .clk(slaveClk), .rst(rst), .txWord(sTx),
    .txLoad(txLoad), .txBusy(txBusy), .rxWord(sRx), .rxValid(sRxValid),
    .idleTimeoutBeforeSleep(idleTimeout), .sleepWanted(sleepWanted),
    .sleepAllowed(sleepAllowed));
  sfsl_link_chk sfsl_link_chk_i (.clk(clk), .rst(rst), .sclk(sfsl_link_if_i.sclk),
    .mosi(sfsl_link_if_i.mosi), .miso(sfsl_link_if_i.miso), .misoOe(sfsl_link_if_i.misoOe),
    .targetSelectLow_n(sfsl_link_if_i.targetSelectLow_n), .irq(sfsl_link_if_i.irq));
  always #5 clk = ~clk;
  // offset start keeps the two clocks out of phase
  initial begin
    #3;
    forever #16 slaveClk = ~slaveClk;
  end
  always @(posedge slaveClk) if (sRxValid === 1'b1) sGot <= sRx;
  always @(posedge clk) if (mRxValid === 1'b1) mGot <= mRx;
  always @(posedge clk) if (requestSeen === 1'b1) reqCount <= reqCount + 1;
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic slave_load(input logic [7:0] w);
    @(posedge slaveClk);
    #1;
    sTx = w;
    txLoad = 1'b1;
    @(posedge slaveClk);
    #1;
    txLoad = 1'b0;
  endtask
  task automatic master_xfer(input logic [7:0] w);
    @(posedge clk);
    #1;
    mTx = w;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    // a real rising edge on reset, so every async branch is taken
    #1;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    check("select", 16'h0001, 16'(sfsl_link_if_i.targetSelectLow_n));
    check("sclk", 16'h0000, 16'(sfsl_link_if_i.sclk));
    check("misoOe", 16'h0000, 16'(sfsl_link_if_i.misoOe));
    check("timeout", sfsl_pkg::TIMEOUT_NEVER, idleTimeout);
    @(posedge slaveClk);
    #1;
    sleepWanted = 1'b1;
    repeat (40) @(posedge clk);
    check("sleepAllowed", 16'h0000, 16'(sleepAllowed));
    for (int k = 0; k < 2; k++) begin
      slave_load(sw[k]);
      for (int i = 0; i < 50 && reqCount != k + 1; i++) @(posedge clk);
      check("requestSeen", 16'(k + 1), 16'(reqCount));
      check("irq", 16'h0001, 16'(sfsl_link_if_i.irq));
      master_xfer(mw[k]);
      repeat (20) @(posedge clk);
      check("master rxWord", 16'(sw[k]), 16'(mGot));
      check("slave rxWord", 16'(mw[k]), 16'(sGot));
      check("irq after select", 16'h0000, 16'(sfsl_link_if_i.irq));
      check("request count", 16'(k + 1), 16'(reqCount));
    end
    print_verdict();
  end
  // no run of these tests comes near this span
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule
